// >>> inc/tcs_regs.vh
// register map, field layout and timing constants of the trace capture and search block
// Operation
// - dma cycles captured only when enabled
// - overflow raises break only when enabled
// - unit zero stores clock cycle counts
// - units one to three: 20ns, 1.6us, 52us; unit one advances once per 50ns clock
// - mode settings readable by software
// - conditionless search returns instruction, cycle counts
// - search only between start and end pointers
// - omitted pointers use default pointer registers
// - last match option keeps final hit only
// - all enabled conditions are anded
// - address exact or range, maskable
// - data maskable, byte word longword size
// - read or write selection matches direction
// - execution or dma type, or all
// - probe byte compared per bit, maskable
// - reset defaults: dma on, break off, 20ns
// - pointers clamped to plus minus 131070
`ifndef TCS_REGS_VH
`define TCS_REGS_VH
`define TCS_MODE_OFS      12'h000
`define TCS_CNT_OFS       12'h004
`define TCS_DEFPTR_S_OFS  12'h008
`define TCS_DEFPTR_E_OFS  12'h00c
`define TCS_SPTR_OFS      12'h010
`define TCS_EPTR_OFS      12'h014
`define TCS_SCTL_OFS      12'h018
`define TCS_ADDR1_OFS     12'h01c
`define TCS_ADDR2_OFS     12'h020
`define TCS_AMASK_OFS     12'h024
`define TCS_DATA_OFS      12'h028
`define TCS_DMASK_OFS     12'h02c
`define TCS_PROBE_OFS     12'h030
`define TCS_SSTAT_OFS     12'h034
`define TCS_HITS_OFS      12'h038
`define TCS_HITPTR_OFS    12'h03c
`define TCS_ISTAT_OFS     12'h040
`define TCS_IMASK_OFS     12'h044
// mode register fields
`define TCS_MODE_DMA_BIT  0
`define TCS_MODE_OVERFLOW_BREAK_ENABLE_BIT 1
`define TCS_MODE_TU_LSB   2
`define TCS_MODE_RST      32'h0000_0005
// search control fields
`define TCS_SC_GO_BIT     0
`define TCS_SC_LAST_BIT   1
`define TCS_SC_USEPTR_BIT 2
`define TCS_SC_AEN_BIT    3
`define TCS_SC_ARNG_BIT   4
`define TCS_SC_DEN_BIT    5
`define TCS_SC_DSZ_LSB    6
`define TCS_SC_RWEN_BIT   8
`define TCS_SC_RWW_BIT    9
`define TCS_SC_TEN_BIT    10
`define TCS_SC_TDMA_BIT   11
`define TCS_SC_PEN_BIT    12
// access types and sizes
`define TCS_TYPE_FETCH    2'h0
`define TCS_TYPE_EXEC     2'h1
`define TCS_TYPE_DMA      2'h2
`define TCS_SZ_BYTE       2'h0
`define TCS_SZ_WORD       2'h1
`define TCS_SZ_LONG       2'h2
// pointer limit and default pointers
`define TCS_PTR_LIM       18'd131070
`define TCS_DEFPTR_RST    18'd4095
// time stamp units in picoseconds and clock period
`define TCS_CLK_PS        50000
`define TCS_TU1_PS        20000
`define TCS_TU2_PS        1600000
`define TCS_TU3_PS        52000000
// interrupt bits
`define TCS_INT_OVF_BIT   0
`define TCS_INT_DONE_BIT  1
`endif

// >>> verilog/tcs_stamp.v
// time stamp prescaler and counter of the trace capture block
`timescale 1ns/1ns
`include "tcs_regs.vh"
module tcs_stamp #(
    parameter TW = 24
) (
    // clock and reset
    input  wire          clk_i,
    input  wire          rst_b_i,
    // unit select
    input  wire [1:0]    unit_i,
    // stamp value
    output reg  [TW-1:0] stamp_o
);
    // cycles per tick; a unit finer than the clock still advances once a cycle
    localparam integer C1 = (`TCS_TU1_PS + `TCS_CLK_PS - 1) / `TCS_CLK_PS;
    localparam integer C2 = (`TCS_TU2_PS + `TCS_CLK_PS - 1) / `TCS_CLK_PS;
    localparam integer C3 = (`TCS_TU3_PS + `TCS_CLK_PS - 1) / `TCS_CLK_PS;
    reg  [20:0] div_ff;
    reg  [20:0] lim;
    wire        tick = (div_ff >= lim);

    always @* begin
        case (unit_i)
            2'h0:    lim = 21'h0;           // clock count: every cycle
            2'h1:    lim = C1[20:0] - 21'h1;
            2'h2:    lim = C2[20:0] - 21'h1;
            default: lim = C3[20:0] - 21'h1;
        endcase
    end

    // divider produces one-cycle tick enable
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_ff  <= 21'h0;
            stamp_o <= {TW{1'b0}};
        end else begin
            div_ff <= tick ? 21'h0 : div_ff + 21'h1;
            if (tick) begin
                stamp_o <= stamp_o + {{(TW-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule // tcs_stamp

// >>> verilog/tcs_trace.v
// trace capture buffer, search engine and apb register file
`timescale 1ns/1ns
`include "tcs_regs.vh"
module tcs_trace #(
    parameter AW    = 32,
    parameter DEPTH = 131072,
    parameter PW    = 17,
    parameter TW    = 24
) (
    // clock and reset
    input  wire          SYS_CLK_I,
    input  wire          RST_B_I,
    // apb slave
    input  wire          PSEL_I,
    input  wire          PENABLE_I,
    input  wire          PWRITE_I,
    input  wire [11:0]   PADDR_I,
    input  wire [31:0]   PWDATA_I,
    output reg  [31:0]   PRDATA_O,
    output reg           PREADY_O,
    output reg           PSLVERR_O,
    // target bus sample, asynchronous to this clock
    input  wire          BUS_VALID_I,
    input  wire [AW-1:0] BUS_ADDR_I,
    input  wire [31:0]   BUS_DATA_I,
    input  wire [1:0]    BUS_SIZE_I,
    input  wire          BUS_WRITE_I,
    input  wire [1:0]    BUS_TYPE_I,
    input  wire          BUS_INSN_I,
    input  wire [7:0]    PROBE_I,
    // break and interrupt
    output reg           BREAK_O,
    output reg           IRQ_O
);
    localparam EW = AW + 32 + 2 + 1 + 2 + 8 + TW;
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_RUN  = 3'h1;
    localparam [2:0] S_CHK  = 3'h2;
    localparam [2:0] S_DONE = 3'h3;

    // two-flop synchronisers for all target bus inputs
    localparam SW = 1 + AW + 32 + 2 + 1 + 2 + 1 + 8;
    reg  [SW-1:0] sy1_ff;
    reg  [SW-1:0] sy2_ff;
    reg           vld_d_ff;
    always @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            sy1_ff   <= {SW{1'b0}};
            sy2_ff   <= {SW{1'b0}};
            vld_d_ff <= 1'b0;
        end else begin
            sy1_ff   <= {BUS_VALID_I, BUS_ADDR_I, BUS_DATA_I, BUS_SIZE_I, BUS_WRITE_I,
                         BUS_TYPE_I, BUS_INSN_I, PROBE_I};
            sy2_ff   <= sy1_ff;
            vld_d_ff <= sy2_ff[SW-1];
        end
    end
    // the sampler holds fields steady around its valid level, so one edge stores one cycle
    wire          s_vld  = sy2_ff[SW-1] & ~vld_d_ff;
    wire [AW-1:0] s_addr = sy2_ff[SW-2 -: AW];
    wire [31:0]   s_data = sy2_ff[SW-2-AW -: 32];
    wire [1:0]    s_size = sy2_ff[13:12];
    wire          s_wr   = sy2_ff[11];
    wire [1:0]    s_type = sy2_ff[10:9];
    wire          s_insn = sy2_ff[8];
    wire [7:0]    s_prb  = sy2_ff[7:0];

    // software registers
    reg  [31:0] mode_ff;
    reg  [17:0] defs_ff, defe_ff, sptr_ff, eptr_ff;
    reg  [12:0] sctl_ff;
    reg  [AW-1:0] a1_ff, a2_ff, am_ff;
    reg  [31:0] dv_ff, dm_ff;
    reg  [15:0] prb_ff;
    reg  [1:0]  ist_ff, imsk_ff;
    wire [1:0]  tunit = mode_ff[`TCS_MODE_TU_LSB +: 2];
    wire [TW-1:0] stamp;

    tcs_stamp #(.TW(TW)) u_stamp (
        .clk_i   (SYS_CLK_I),
        .rst_b_i (RST_B_I),
        .unit_i  (tunit),
        .stamp_o (stamp)
    );

    // trace memory and fill state
    reg  [EW-1:0] mem [0:DEPTH-1];
    reg  [PW-1:0] wp_ff;
    reg  [PW:0]   nbus_ff;
    reg  [PW:0]   nins_ff;
    wire cap_ok = s_vld & ((s_type != `TCS_TYPE_DMA) | mode_ff[`TCS_MODE_DMA_BIT]);
    wire full   = (nbus_ff == DEPTH[PW:0]);
    wire ovf_ev = cap_ok & full;
    wire [2*PW+33:0] cnt_x = {16'h0, nins_ff, 16'h0, nbus_ff};

    // store entry; stamp field carries clock count in unit zero
    always @(posedge SYS_CLK_I) begin
        if (cap_ok) begin
            mem[wp_ff] <= {s_addr, s_data, s_size, s_wr, s_type, s_prb, stamp};
        end
    end

    reg [2:0] st_ff;
    always @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            wp_ff   <= {PW{1'b0}};
            nbus_ff <= {(PW+1){1'b0}};
            nins_ff <= {(PW+1){1'b0}};
            BREAK_O <= 1'b0;
        end else begin
            BREAK_O <= ovf_ev & mode_ff[`TCS_MODE_OVERFLOW_BREAK_ENABLE_BIT];
            if (cap_ok) begin
                wp_ff <= wp_ff + {{(PW-1){1'b0}}, 1'b1};
                if (!full) begin
                    nbus_ff <= nbus_ff + {{PW{1'b0}}, 1'b1};
                end
                if (s_insn && nins_ff != DEPTH[PW:0]) begin
                    nins_ff <= nins_ff + {{PW{1'b0}}, 1'b1};
                end
            end
        end
    end

    // clamp a signed pointer to the documented limits
    function [17:0] clamp;
        input [31:0] v;
        begin
            if ($signed(v) > $signed({14'h0, `TCS_PTR_LIM})) begin
                clamp = `TCS_PTR_LIM;
            end else if ($signed(v) < -$signed({14'h0, `TCS_PTR_LIM})) begin
                clamp = -`TCS_PTR_LIM;
            end else begin
                clamp = v[17:0];
            end
        end
    endfunction

    // search engine: pointer 0 is newest entry, negative values are older
    reg  [17:0] cur_ff, end_ff;
    reg  [EW-1:0] ent_ff;
    reg  [PW:0] hits_ff;
    reg  [17:0] hptr_ff;
    reg         busy_ff;
    wire        go = sctl_ff[`TCS_SC_GO_BIT];
    wire [17:0] rs = sctl_ff[`TCS_SC_USEPTR_BIT] ? sptr_ff : defs_ff;
    wire [17:0] re = sctl_ff[`TCS_SC_USEPTR_BIT] ? eptr_ff : defe_ff;
    wire [PW-1:0] ridx = wp_ff - {{(PW-1){1'b0}}, 1'b1} + cur_ff[PW-1:0];
    wire [17:0] age = -cur_ff;
    wire        inrng = ($signed(cur_ff) <= 18'sd0) && ({1'b0, age} < {1'b0, nbus_ff});

    // entry field views
    wire [AW-1:0] e_addr = ent_ff[EW-1 -: AW];
    wire [31:0]   e_data = ent_ff[EW-1-AW -: 32];
    wire [1:0]    e_size = ent_ff[TW+11 +: 2];
    wire          e_wr   = ent_ff[TW+10];
    wire [1:0]    e_type = ent_ff[TW+8 +: 2];
    wire [7:0]    e_prb  = ent_ff[TW +: 8];
    wire [AW-1:0] ma     = e_addr & ~am_ff;
    wire a_ok = !sctl_ff[`TCS_SC_AEN_BIT] ||
                (sctl_ff[`TCS_SC_ARNG_BIT] ? (ma >= (a1_ff & ~am_ff) && ma <= (a2_ff & ~am_ff))
                                           : (ma == (a1_ff & ~am_ff)));
    wire d_ok = !sctl_ff[`TCS_SC_DEN_BIT] ||
                (((e_data ^ dv_ff) & ~dm_ff) == 32'h0 &&
                 e_size == sctl_ff[`TCS_SC_DSZ_LSB +: 2]);
    wire rw_ok = !sctl_ff[`TCS_SC_RWEN_BIT] || (e_wr == sctl_ff[`TCS_SC_RWW_BIT]);
    wire t_ok = !sctl_ff[`TCS_SC_TEN_BIT] ||
                (e_type == (sctl_ff[`TCS_SC_TDMA_BIT] ? `TCS_TYPE_DMA : `TCS_TYPE_EXEC));
    wire p_ok = !sctl_ff[`TCS_SC_PEN_BIT] ||
                (((e_prb ^ prb_ff[7:0]) & ~prb_ff[15:8]) == 8'h0);
    wire hit  = a_ok & d_ok & rw_ok & t_ok & p_ok;
    wire any_cond = sctl_ff[`TCS_SC_AEN_BIT] | sctl_ff[`TCS_SC_DEN_BIT] |
                    sctl_ff[`TCS_SC_RWEN_BIT] | sctl_ff[`TCS_SC_TEN_BIT] |
                    sctl_ff[`TCS_SC_PEN_BIT];
    reg  valid_ff;
    wire done_ev = (st_ff == S_DONE);

    // search walks one entry per two cycles: read then compare
    always @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            st_ff    <= S_IDLE;
            cur_ff   <= 18'h0;
            end_ff   <= 18'h0;
            ent_ff   <= {EW{1'b0}};
            hits_ff  <= {(PW+1){1'b0}};
            hptr_ff  <= 18'h0;
            busy_ff  <= 1'b0;
            valid_ff <= 1'b0;
        end else begin
            case (st_ff)
                S_IDLE: begin
                    if (go) begin
                        busy_ff <= 1'b1;
                        hits_ff <= {(PW+1){1'b0}};
                        cur_ff  <= rs;
                        end_ff  <= re;
                        st_ff   <= any_cond ? S_RUN : S_DONE;
                    end
                end
                S_RUN: begin
                    valid_ff <= inrng;
                    ent_ff   <= mem[ridx];
                    st_ff    <= S_CHK;
                end
                S_CHK: begin
                    if (valid_ff && hit) begin
                        // last-only mode keeps just the newest hit pointer
                        hits_ff <= sctl_ff[`TCS_SC_LAST_BIT] ? {{PW{1'b0}}, 1'b1}
                                                             : hits_ff + {{PW{1'b0}}, 1'b1};
                        hptr_ff <= cur_ff;
                    end
                    if ($signed(cur_ff) >= $signed(end_ff)) begin
                        st_ff <= S_DONE;
                    end else begin
                        cur_ff <= cur_ff + 18'h1;
                        st_ff  <= S_RUN;
                    end
                end
                S_DONE: begin
                    busy_ff <= 1'b0;
                    st_ff   <= S_IDLE;
                end
                default: st_ff <= S_IDLE;
            endcase
        end
    end

    // apb: one wait-free access; write at the access phase
    wire wr_en = PSEL_I & PENABLE_I & PWRITE_I;
    wire rd_en = PSEL_I & ~PENABLE_I & ~PWRITE_I;
    reg  [31:0] rdat;
    reg         known;
    always @* begin
        known = 1'b1;
        rdat  = 32'h0;
        case (PADDR_I)
            `TCS_MODE_OFS:     rdat = {28'h0, mode_ff[3:0]};
            `TCS_CNT_OFS:      rdat = {cnt_x[PW+32 -: 16], cnt_x[15:0]};
            `TCS_DEFPTR_S_OFS: rdat = {{14{defs_ff[17]}}, defs_ff};
            `TCS_DEFPTR_E_OFS: rdat = {{14{defe_ff[17]}}, defe_ff};
            `TCS_SPTR_OFS:     rdat = {{14{sptr_ff[17]}}, sptr_ff};
            `TCS_EPTR_OFS:     rdat = {{14{eptr_ff[17]}}, eptr_ff};
            `TCS_SCTL_OFS:     rdat = {19'h0, sctl_ff};
            `TCS_ADDR1_OFS:    rdat = a1_ff;
            `TCS_ADDR2_OFS:    rdat = a2_ff;
            `TCS_AMASK_OFS:    rdat = am_ff;
            `TCS_DATA_OFS:     rdat = dv_ff;
            `TCS_DMASK_OFS:    rdat = dm_ff;
            `TCS_PROBE_OFS:    rdat = {16'h0, prb_ff};
            `TCS_SSTAT_OFS:    rdat = {31'h0, busy_ff};
            `TCS_HITS_OFS:     rdat = {{(31-PW){1'b0}}, hits_ff};
            `TCS_HITPTR_OFS:   rdat = {{14{hptr_ff[17]}}, hptr_ff};
            `TCS_ISTAT_OFS:    rdat = {30'h0, ist_ff};
            `TCS_IMASK_OFS:    rdat = {30'h0, imsk_ff};
            default:           known = 1'b0;
        endcase
    end

    always @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            mode_ff   <= `TCS_MODE_RST;
            defs_ff   <= -`TCS_DEFPTR_RST;
            defe_ff   <= `TCS_DEFPTR_RST;
            sptr_ff   <= 18'h0;
            eptr_ff   <= 18'h0;
            sctl_ff   <= 13'h0;
            a1_ff     <= {AW{1'b0}};
            a2_ff     <= {AW{1'b0}};
            am_ff     <= {AW{1'b0}};
            dv_ff     <= 32'h0;
            dm_ff     <= 32'h0;
            prb_ff    <= 16'h0;
            ist_ff    <= 2'h0;
            imsk_ff   <= 2'h0;
            PRDATA_O  <= 32'h0;
            PREADY_O  <= 1'b0;
            PSLVERR_O <= 1'b0;
            IRQ_O     <= 1'b0;
        end else begin
            PREADY_O  <= PSEL_I & ~PENABLE_I;
            PSLVERR_O <= PSEL_I & ~PENABLE_I & ~known;
            if (rd_en) begin
                PRDATA_O <= rdat;
            end
            // go is a self-clearing strobe
            if (st_ff == S_IDLE) begin
                sctl_ff[`TCS_SC_GO_BIT] <= 1'b0;
            end
            if (wr_en && PREADY_O) begin
                case (PADDR_I)
                    `TCS_MODE_OFS:     mode_ff  <= {28'h0, PWDATA_I[3:0]};
                    `TCS_DEFPTR_S_OFS: defs_ff  <= clamp(PWDATA_I);
                    `TCS_DEFPTR_E_OFS: defe_ff  <= clamp(PWDATA_I);
                    `TCS_SPTR_OFS:     sptr_ff  <= clamp(PWDATA_I);
                    `TCS_EPTR_OFS:     eptr_ff  <= clamp(PWDATA_I);
                    `TCS_SCTL_OFS:     sctl_ff  <= busy_ff ? sctl_ff : PWDATA_I[12:0];
                    `TCS_ADDR1_OFS:    a1_ff    <= PWDATA_I[AW-1:0];
                    `TCS_ADDR2_OFS:    a2_ff    <= PWDATA_I[AW-1:0];
                    `TCS_AMASK_OFS:    am_ff    <= PWDATA_I[AW-1:0];
                    `TCS_DATA_OFS:     dv_ff    <= PWDATA_I;
                    `TCS_DMASK_OFS:    dm_ff    <= PWDATA_I;
                    `TCS_PROBE_OFS:    prb_ff   <= PWDATA_I[15:0];
                    `TCS_IMASK_OFS:    imsk_ff  <= PWDATA_I[1:0];
                    default: ;
                endcase
            end
            // sticky events: a set in the clearing cycle wins
            ist_ff <= (ist_ff & ~((wr_en && PREADY_O && PADDR_I == `TCS_ISTAT_OFS) ?
                                  PWDATA_I[1:0] : 2'h0)) | {done_ev, ovf_ev};
            IRQ_O  <= |(ist_ff & imsk_ff);
        end
    end
endmodule // tcs_trace

// >>> tb/tcs_trace_assertions.sv
// port checker of the trace capture and search block
`timescale 1ns/1ns
module tcs_trace_assertions (
    // clock and reset
    input wire        SYS_CLK_I,
    input wire        RST_B_I,
    // apb slave
    input wire        PSEL_I,
    input wire        PENABLE_I,
    input wire        PWRITE_I,
    input wire [11:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    input wire [31:0] PRDATA_O,
    input wire        PREADY_O,
    input wire        PSLVERR_O,
    // break and interrupt
    input wire        BREAK_O,
    input wire        IRQ_O
);
    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!RST_B_I);
    // mode shadow follows completed writes so read-back can be judged
    logic [3:0] mode_ff;
    wire        wr_acc = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
    wire        rd_acc = PSEL_I && PENABLE_I && PREADY_O && !PWRITE_I;
    always @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            mode_ff <= 4'h5;
        end else if (wr_acc && PADDR_I == 12'h000) begin
            mode_ff <= PWDATA_I[3:0];
        end
    end
    property p_ready_after_setup;
        PSEL_I && !PENABLE_I |=> PREADY_O;
    endproperty
    a_ready_after_setup: assert property (p_ready_after_setup) else $error("ready late");
    property p_ready_pulse;
        PREADY_O |=> !PREADY_O;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
    property p_err_unmapped;
        PSLVERR_O |-> PREADY_O && PADDR_I > 12'h044;
    endproperty
    a_err_unmapped: assert property (p_err_unmapped) else $error("bad slave error");
    property p_err_zero;
        rd_acc && PSLVERR_O |-> PRDATA_O == 32'h0;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("unmapped data not zero");
    property p_mode_read;
        rd_acc && PADDR_I == 12'h000 |-> PRDATA_O[3:0] == mode_ff;
    endproperty
    a_mode_read: assert property (p_mode_read) else $error("mode read-back wrong");
    property p_break_pulse;
        BREAK_O |=> !BREAK_O;
    endproperty
    a_break_pulse: assert property (p_break_pulse) else $error("break too long");
    property p_break_en;
        BREAK_O |-> mode_ff[1] || $past(mode_ff[1]);
    endproperty
    a_break_en: assert property (p_break_en) else $error("break while disabled");
    // irq is registered from status, so a cleared mask shows two edges later
    property p_irq_masked;
        wr_acc && PADDR_I == 12'h044 && PWDATA_I[1:0] == 2'h0 |-> ##2 !IRQ_O;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("irq with mask off");
    c_break: cover property (BREAK_O);
    c_irq: cover property (IRQ_O);
    c_err: cover property (PSLVERR_O);
endmodule // tcs_trace_assertions
bind tcs_trace tcs_trace_assertions tcs_trace_assertions_inst (
    .SYS_CLK_I (SYS_CLK_I),
    .RST_B_I   (RST_B_I),
    .PSEL_I    (PSEL_I),
    .PENABLE_I (PENABLE_I),
    .PWRITE_I  (PWRITE_I),
    .PADDR_I   (PADDR_I),
    .PWDATA_I  (PWDATA_I),
    .PRDATA_O  (PRDATA_O),
    .PREADY_O  (PREADY_O),
    .PSLVERR_O (PSLVERR_O),
    .BREAK_O   (BREAK_O),
    .IRQ_O     (IRQ_O)
);

// >>> tb/tcs_bus_model.sv
// target bus model presenting bus cycles to the trace capture inputs
`timescale 1ns/1ns
module tcs_bus_model (
    // pacing clock
    input  wire        clk_i,
    // target bus sample
    output reg         valid_o,
    output reg  [31:0] addr_o,
    output reg  [31:0] data_o,
    output reg  [1:0]  size_o,
    output reg         write_o,
    output reg  [1:0]  type_o,
    output reg         insn_o,
    output reg  [7:0]  probe_o
);
    // fields settle three clocks before valid rises and stay until three plus gap clocks after it falls
    task automatic push(input [31:0] a, d, input [1:0] sz, input w, input [1:0] ty,
                        input ins, input [7:0] pr, input int gap);
        @(posedge clk_i);
        {addr_o, data_o, size_o, write_o, type_o, insn_o, probe_o} <= {a, d, sz, w, ty, ins, pr};
        repeat (3) @(posedge clk_i);
        valid_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        valid_o <= 1'b0;
        repeat (3 + gap) @(posedge clk_i);
        // released fields turn to their inverse so a late sample shows up as a miss
        {addr_o, data_o, size_o, write_o, type_o, insn_o, probe_o} <= ~{a, d, sz, w, ty, ins, pr};
    endtask
    initial begin
        valid_o = 1'b0;
        {addr_o, data_o, size_o, write_o, type_o, insn_o, probe_o} = 80'h0;
    end
endmodule // tcs_bus_model

// >>> tb/tcs_trace_tb.sv
// self-checking testbench of the trace capture and search block
`timescale 1ns/1ns
module tcs_trace_tb;
    // clock, reset and apb master
    logic        sys_clk, rst_b, psel, penable, pwrite, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    wire  [31:0] prdata, addr, data;
    wire         pready, pslverr, valid, wr, ins, brk, irq;
    wire  [1:0]  size, typ;
    wire  [7:0]  probe;
    // stored entries, search settings and counters
    logic [31:0] e_a [8], e_d [8], c_ctl, c_a1, c_a2, c_am, c_d, c_dm, c_pr;
    logic [1:0]  e_sz [8], e_ty [8];
    logic [7:0]  e_p [8];
    logic        e_w [8], e_i [8];
    integer      n_fail, n_compared, n_brk, seed, s, e, n, lp, k, i, t, nins;
    // small buffer keeps the overflow run short
    tcs_trace #(.DEPTH(64), .PW(6)) tcs_trace_inst (
        .SYS_CLK_I(sys_clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .BUS_VALID_I(valid), .BUS_ADDR_I(addr),
        .BUS_DATA_I(data), .BUS_SIZE_I(size), .BUS_WRITE_I(wr), .BUS_TYPE_I(typ),
        .BUS_INSN_I(ins), .PROBE_I(probe), .BREAK_O(brk), .IRQ_O(irq));
    tcs_bus_model tcs_bus_model_inst (
        .clk_i(sys_clk), .valid_o(valid), .addr_o(addr), .data_o(data), .size_o(size),
        .write_o(wr), .type_o(typ), .insn_o(ins), .probe_o(probe));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // count break pulses
    always @(posedge sys_clk) n_brk <= (rst_b !== 1'b1) ? 0 : n_brk + (brk === 1'b1);
    task automatic check(input string what, input [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one apb transfer after an idle edge; waits for ready, bounded
    task automatic apb(input w, input [11:0] a, input [31:0] d);
        @(posedge sys_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge sys_clk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        if (t >= 50) begin n_fail++; complete_run; end
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic rdc(input string what, input [11:0] a, input [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, rd, exp);
    endtask
    // start a search and poll busy, bounded
    task automatic run_search(input [31:0] ctl);
        apb(1'b1, 12'h018, ctl);
        i = 0;
        do begin
            apb(1'b0, 12'h034, 32'h0);
            i++;
        end while (rd[0] !== 1'b0 && i < 400);
        check("busy", rd[0], 0);
        if (rd[0] !== 1'b0) complete_run;
        repeat (2) @(posedge sys_clk);
    endtask
    // expected match of entry j under the current search settings
    function automatic logic hit(input int j);
        logic m;
        m = 1'b1;
        if (c_ctl[3]) m &= c_ctl[4] ? (e_a[j] >= c_a1 && e_a[j] <= c_a2)
                                    : ((e_a[j] ^ c_a1) & ~c_am) == 0;
        if (c_ctl[5]) m &= ((e_d[j] ^ c_d) & ~c_dm) == 0 && e_sz[j] == c_ctl[7:6];
        if (c_ctl[8]) m &= e_w[j] == c_ctl[9];
        if (c_ctl[10]) m &= e_ty[j] == (c_ctl[11] ? 2'h2 : 2'h1);
        if (c_ctl[12]) m &= ((e_p[j] ^ c_pr[7:0]) & ~c_pr[15:8]) == 0;
        return m;
    endfunction
    task automatic complete_run;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // watchdog, well beyond the few thousand cycles the tests take
    initial begin
        #2000000;
        n_fail++;
        complete_run;
    end
    initial begin
        {seed, n_fail, n_compared, nins} = {32'h8265143c, 32'h0, 32'h0, 32'h1};
        {rst_b, psel, penable, pwrite, paddr, pwdata} = 48'h0;
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'b1;
        rdc("mode_rst", 12'h000, 32'h5);
        rdc("defend", 12'h00c, 32'd4095);
        apb(1'b1, 12'h044, 32'h3);
        run_search(32'h1);
        check("irq_done", irq, 1);
        rdc("cnt0", 12'h004, 32'h0);
        apb(1'b0, 12'h048, 32'h0);
        check("unmapped_err", err, 1);
        check("unmapped_data", rd, 0);
        apb(1'b1, 12'h014, 32'd200000);
        rdc("clamp_hi", 12'h014, 32'd131070);
        apb(1'b1, 12'h010, -32'sd200000);
        apb(1'b0, 12'h010, 32'h0);
        check("clamp_lo", rd & 32'h3ffff, -32'sd131070 & 32'h3ffff);
        for (k = 0; k < 4; k++) begin
            c_ctl = {28'h0, k[1:0], 1'($random(seed)), 1'b1};
            apb(1'b1, 12'h000, c_ctl);
            rdc("mode", 12'h000, c_ctl);
        end
        $display("test registers done");
        apb(1'b1, 12'h000, 32'h4);
        tcs_bus_model_inst.push(32'h100, 32'h0, 2'h2, 1'b0, 2'h2, 1'b0, 8'h0, 0);
        tcs_bus_model_inst.push(32'h104, 32'h0, 2'h2, 1'b0, 2'h0, 1'b1, 8'h0, 5);
        run_search(32'h1);
        rdc("cnt_dma_off", 12'h004, 32'h00010001);
        apb(1'b1, 12'h000, 32'h5);
        for (k = 0; k < 8; k++) begin
            {e_a[k], e_d[k]} = {32'h1000 + ($random(seed) & 32'hff), 32'($random(seed))};
            {e_sz[k], e_ty[k]} = {2'($unsigned($random(seed)) % 3), 2'($unsigned($random(seed)) % 3)};
            {e_w[k], e_i[k], e_p[k]} = 10'($random(seed));
            if (k == 0) e_ty[k] = 2'h2;
            nins += e_i[k];
            tcs_bus_model_inst.push(e_a[k], e_d[k], e_sz[k], e_w[k], e_ty[k], e_i[k], e_p[k], k % 3);
        end
        run_search(32'h1);
        rdc("cnt", 12'h004, {nins[15:0], 16'd9});
        $display("test capture done");
        for (k = 0; k < 20; k++) begin
            i = $unsigned($random(seed)) % 8;
            s = -($unsigned($random(seed)) % 8);
            e = s + $unsigned($random(seed)) % (1 - s);
            c_ctl = ($random(seed) & 32'h153e) | 32'h1;
            {c_ctl[11], c_ctl[9], c_ctl[7:6]} = {e_ty[i] == 2'h2, e_w[i], e_sz[i]};
            if ((c_ctl & 32'h1528) == 0) c_ctl[3] = 1'b1;
            {c_a1, c_d, c_dm} = {e_a[i], e_d[i], $random(seed) & 32'hf};
            c_a2 = c_a1 + ($random(seed) & 32'h3f);
            c_am = c_ctl[4] ? 32'h0 : $random(seed) & 32'h3;
            c_pr = {16'h0, 8'($random(seed) & 8'h0f), e_p[i]};
            apb(1'b1, 12'h01c, c_a1);
            apb(1'b1, 12'h020, c_a2);
            apb(1'b1, 12'h024, c_am);
            apb(1'b1, 12'h028, c_d);
            apb(1'b1, 12'h02c, c_dm);
            apb(1'b1, 12'h030, c_pr);
            apb(1'b1, c_ctl[2] ? 12'h010 : 12'h008, s);
            apb(1'b1, c_ctl[2] ? 12'h014 : 12'h00c, e);
            apb(1'b1, 12'h044, {30'h0, k[0], 1'b0});
            apb(1'b1, 12'h040, 32'h3);
            run_search(c_ctl);
            check("irq_mask", irq, k[0]);
            {n, lp} = 64'h0;
            for (int j = 0; j < 8; j++) begin
                if (j - 7 >= s && j - 7 <= e && hit(j)) {n, lp} = {n + 1, j - 7};
            end
            rdc("hits", 12'h038, c_ctl[1] ? (n > 0) : n);
            apb(1'b0, 12'h03c, 32'h0);
            if (n > 0) check("hitptr", rd & 32'hffff, lp & 32'hffff);
        end
        $display("test search done");
        apb(1'b1, 12'h040, 32'h3);
        for (k = 0; k < 57; k++) tcs_bus_model_inst.push(k, k, 2'h2, 1'b1, 2'h1, 1'b0, 8'h0, k % 2);
        rdc("istat_ovf", 12'h040, 32'h1);
        check("no_break", n_brk, 0);
        apb(1'b1, 12'h000, 32'h7);
        tcs_bus_model_inst.push(32'h0, 32'h0, 2'h2, 1'b1, 2'h1, 1'b0, 8'h0, 2);
        check("break", n_brk, 1);
        $display("test overflow done");
        complete_run;
    end
endmodule // tcs_trace_tb
